// ===== hdl/csp_pkg.sv
package csp_pkg;

  //////////////////////////////////////////////////////////////////////////
  // Register indices (byte address is four times the index)
  localparam logic [11:0] IDX_BUF_FIRST = 12'hf90;
  localparam logic [11:0] IDX_BUF_LAST  = 12'hf97;
  localparam logic [11:0] IDX_CTRL_ONE  = 12'hf98;
  localparam logic [11:0] IDX_CTRL_TWO  = 12'hf99;
  localparam logic [11:0] IDX_STATUS    = 12'hf99;
  localparam logic [11:0] IDX_CFG       = 12'hf9a;

  //////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int unsigned RUN_BIT    = 7;
  localparam int unsigned ABORT_BIT  = 6;
  localparam int unsigned MODE_LSB   = 3;
  localparam int unsigned SCK_LSB    = 0;
  localparam int unsigned WAIT_LSB   = 3;
  localparam int unsigned COUNT_LSB  = 0;
  localparam int unsigned STAT_XFER  = 7;
  localparam int unsigned STAT_SHIFT = 6;
  localparam int unsigned CFG_TAP    = 0;

  //////////////////////////////////////////////////////////////////////////
  // Values after reset
  localparam logic [2:0] MODE_RST  = 3'h0;
  localparam logic [2:0] SCK_RST   = 3'h0;
  localparam logic [1:0] WAIT_RST  = 2'h0;
  localparam logic [2:0] COUNT_RST = 3'h0;
  localparam logic       TAP_RST   = 1'b0;

  //////////////////////////////////////////////////////////////////////////
  // Transfer modes
  localparam logic [2:0] MODE_TX8  = 3'h0;
  localparam logic [2:0] MODE_TX4  = 3'h2;
  localparam logic [2:0] MODE_TRX8 = 3'h4;
  localparam logic [2:0] MODE_RX8  = 3'h5;
  localparam logic [2:0] MODE_RX4  = 3'h6;

  //////////////////////////////////////////////////////////////////////////
  // Serial clock selection and half periods in hclk cycles (slow tap: in lowclk rising edges)
  localparam logic [2:0]  CLK_SLOW       = 3'h0;
  localparam logic [2:0]  CLK_RSVD       = 3'h6;
  localparam logic [2:0]  CLK_EXT        = 3'h7;
  localparam logic [12:0] HALF_FC_SLOW   = 13'h1000;
  localparam logic [12:0] HALF_FS_SLOW   = 13'h0010;
  localparam logic [12:0] HALF_FC_CODE1  = 13'h0080;
  localparam logic [3:0]  BITS_WIDE      = 4'h8;
  localparam logic [3:0]  BITS_NARROW    = 4'h4;

  //////////////////////////////////////////////////////////////////////////
  // Sequencer states
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_SHIFT = 2'b01,
    ST_GAP   = 2'b10,
    ST_HOLD  = 2'b11
  } csp_state_e;

endpackage : csp_pkg

// ===== hdl/csp_port.sv
// How it works
// - Internal clock: frame time is 1, 2, 4 or 8 transfer times.
// - Word count field selects one to eight words from entry zero.
// - 4-bit transfers use low nibble; received high nibble stored zero.
// - Transmit from lowest entry; received words stored lowest upward.
// - The word count is never changed by hardware.
// - Status bit 7 shows transfer active, bit 6 shift active.
// - Transfer flag drops at transfer end after stop, at once on abort.
// - Internal clock is driven on the clock pin, high at start.
// - Clock code picks divider, slow tap, reserved or external clock.
// - Internal clock stops and holds when buffer access is late.
// - Data out changes on falling clock, data in sampled on rising.
// - Words move least significant bit first.
// - Interrupt is raised once the programmed words have moved.
// - Next word loads after first bit; empty interrupt after last.
// - Missing data at burst end waits; a buffer write releases, in receive-only modes a buffer read instead.
// - Stop finishes the current word; abort stops at once.
// - External clock: no refill sends a dummy word, then ends; stop ends at the word end.
// - Mode field picks transmit, receive or both; others reserved.
// - Abort bit clears itself after the abort takes effect.
`timescale 1ns/1ps
module csp_port
  import csp_pkg::*;
#(
  parameter int unsigned BUF_WORDS = 8
) (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Serial pins
  input  wire logic        serial_clock_pin_i,
  output logic             serial_clock_pin_o,
  output logic             serial_clock_pin_oe,
  output logic             serial_out_pin,
  input  wire logic        serial_in_pin,
  input  wire logic        lowclk_pin,
  // Event
  output logic             port_irq
);

  if (BUF_WORDS != 8) begin : g_chk
    $error("csp_port: word count field serves exactly eight entries");
  end

  function automatic logic buf_hit(input logic [11:0] idx);
    buf_hit = (idx >= IDX_BUF_FIRST) && (idx <= IDX_BUF_LAST);
  endfunction : buf_hit

  function automatic logic [12:0] half_len(input logic [2:0] sel,
                                           input logic       tap);
    if (sel == CLK_SLOW) begin
      half_len = tap ? HALF_FS_SLOW : HALF_FC_SLOW;
    end else begin
      half_len = HALF_FC_CODE1 >> (sel - 3'h1);
    end
  endfunction : half_len

  //////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic [2:0] pin_raw;
  logic [2:0] lvl;
  logic [2:0] lvl_prev_reg;

  assign pin_raw = {lowclk_pin, serial_in_pin, serial_clock_pin_i};

  for (genvar g = 0; g < 3; g++) begin : g_sync
    csp_sync u_sync (
      .hclk    (hclk),
      .hresetn (hresetn),
      .pin_i   (pin_raw[g]),
      .level_o (lvl[g])
    );
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lvl_prev_reg <= 3'h7;
    end else begin
      lvl_prev_reg <= lvl;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Bus slave
  logic        ap;
  logic        wr_pend_reg;
  logic        wr_pend_next;
  logic [11:0] wr_idx_reg;
  logic [11:0] wr_idx_next;
  logic [31:0] hrdata_reg;
  logic [31:0] hrdata_next;
  logic [7:0]  rd_val;
  logic        wr_c1;
  logic        wr_c2;
  logic        wr_cfg;
  logic        wr_buf;
  logic        rd_buf;

  csp_state_e  state_reg;
  csp_state_e  state_next;
  logic [7:0]  buf_reg [BUF_WORDS];
  logic [7:0]  buf_next [BUF_WORDS];
  logic        tap_reg;
  logic        xfer_act;
  logic        shift_act;

  assign ap        = hsel && hready && htrans[1];
  assign wr_c1     = wr_pend_reg && (wr_idx_reg == IDX_CTRL_ONE);
  assign wr_c2     = wr_pend_reg && (wr_idx_reg == IDX_CTRL_TWO);
  assign wr_cfg    = wr_pend_reg && (wr_idx_reg == IDX_CFG);
  assign wr_buf    = wr_pend_reg && buf_hit(wr_idx_reg);
  assign rd_buf    = ap && !hwrite && buf_hit(haddr[13:2]);
  assign xfer_act  = (state_reg != ST_IDLE);
  assign shift_act = (state_reg == ST_SHIFT);

  always_comb begin
    rd_val = 8'h00;
    if (buf_hit(haddr[13:2])) begin
      rd_val = buf_reg[haddr[4:2]];
    end else if (haddr[13:2] == IDX_STATUS) begin
      rd_val[STAT_XFER]  = xfer_act;
      rd_val[STAT_SHIFT] = shift_act;
    end else if (haddr[13:2] == IDX_CFG) begin
      rd_val[CFG_TAP] = tap_reg;
    end
    wr_pend_next = ap && hwrite;
    wr_idx_next  = ap ? haddr[13:2] : wr_idx_reg;
    hrdata_next  = hrdata_reg;
    if (ap && !hwrite) begin
      hrdata_next = {24'h000000, rd_val};
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_idx_reg  <= 12'h000;
      hrdata_reg  <= 32'h00000000;
    end else begin
      wr_pend_reg <= wr_pend_next;
      wr_idx_reg  <= wr_idx_next;
      hrdata_reg  <= hrdata_next;
    end
  end

  assign hrdata    = hrdata_reg;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  //////////////////////////////////////////////////////////////////////////
  // Transfer engine
  logic        run_reg,   run_next;
  logic        abort_reg, abort_next;
  logic [2:0]  mode_reg,  mode_next;
  logic [2:0]  sel_reg,   sel_next;
  logic [1:0]  wait_reg,  wait_next;
  logic [2:0]  count_reg, count_next;
  logic        tap_next;
  logic [2:0]  idx_reg,   idx_next;
  logic [3:0]  bit_reg,   bit_next;
  logic [7:0]  sr_reg,    sr_next;
  logic [7:0]  rx_reg,    rx_next;
  logic [7:0]  pend_reg,  pend_next;
  logic [12:0] div_reg,   div_next;
  logic [6:0]  gap_reg,   gap_next;
  logic        sck_reg,   sck_next;
  logic        oe_reg,    oe_next;
  logic        so_reg,    so_next;
  logic        irq_reg,   irq_next;
  logic        last_reg,  last_next;
  logic        acc_reg,   acc_next;
  logic        consume;
  logic        ext, four, is_rx, cfg_ok, tick, fall_ev, rise_ev;
  logic        word_end, burst, inc_en, counting;
  logic [3:0]  bits, mult_m1;
  logic [6:0]  gap_tgt;
  logic [2:0]  nidx;
  logic [7:0]  rx_sh, nx_word;
  logic        sr_lsb;

  assign ext      = (sel_reg == CLK_EXT);
  assign four     = (mode_reg == MODE_TX4) || (mode_reg == MODE_RX4);
  assign is_rx    = (mode_reg == MODE_TRX8) || (mode_reg == MODE_RX8) ||
                    (mode_reg == MODE_RX4);
  assign cfg_ok   = (four || mode_reg == MODE_TX8 || is_rx) &&
                    (sel_reg != CLK_RSVD);
  assign bits     = four ? BITS_NARROW : BITS_WIDE;
  assign mult_m1  = (4'h1 << wait_reg) - 4'h1;
  assign gap_tgt  = 7'(mult_m1) * 7'(bits) * 7'h02;
  assign counting = !ext && (state_reg == ST_SHIFT || state_reg == ST_GAP);
  assign inc_en   = !((sel_reg == CLK_SLOW) && tap_reg) ||
                    (lvl[2] && !lvl_prev_reg[2]);
  assign tick     = counting && inc_en &&
                    (div_reg == half_len(sel_reg, tap_reg) - 13'h0001);
  assign fall_ev  = (state_reg == ST_SHIFT) && (ext ?
                    (!lvl[0] && lvl_prev_reg[0]) : (tick && sck_reg));
  assign rise_ev  = (state_reg == ST_SHIFT) && (ext ?
                    (lvl[0] && !lvl_prev_reg[0]) : (tick && !sck_reg));
  assign word_end = rise_ev && (bit_reg == bits - 4'h1);
  assign burst    = (idx_reg == count_reg);
  assign nidx     = burst ? 3'h0 : idx_reg + 3'h1;
  assign rx_sh    = {lvl[1], rx_reg[7:1]};
  assign nx_word  = buf_reg[nidx];
  assign sr_lsb   = sr_reg[0];

  always_comb begin
    run_next   = run_reg;
    abort_next = 1'b0;
    mode_next  = mode_reg;
    sel_next   = sel_reg;
    wait_next  = wait_reg;
    count_next = count_reg;
    tap_next   = tap_reg;
    buf_next   = buf_reg;
    state_next = state_reg;
    idx_next   = idx_reg;
    bit_next   = bit_reg;
    sr_next    = sr_reg;
    rx_next    = rx_reg;
    pend_next  = pend_reg;
    gap_next   = gap_reg;
    sck_next   = sck_reg;
    so_next    = so_reg;
    last_next  = last_reg;
    irq_next   = 1'b0;
    consume    = 1'b0;
    oe_next    = !ext;
    div_next   = 13'h0000;
    if (counting && inc_en) begin
      div_next = tick ? 13'h0000 : div_reg + 13'h0001;
    end
    if (wr_c1) begin
      run_next   = hwdata[RUN_BIT];
      abort_next = hwdata[ABORT_BIT];
      mode_next  = hwdata[MODE_LSB +: 3];
      sel_next   = hwdata[SCK_LSB +: 3];
    end
    if (wr_c2) begin
      wait_next  = hwdata[WAIT_LSB +: 2];
      count_next = hwdata[COUNT_LSB +: 3];
    end
    if (wr_cfg) begin
      tap_next = hwdata[CFG_TAP];
    end
    if (wr_buf) begin
      buf_next[wr_idx_reg[2:0]] = hwdata[7:0];
    end
    case (state_reg)
      ST_IDLE: begin
        if (run_reg && !abort_reg && cfg_ok) begin
          state_next = ST_SHIFT;
          idx_next   = 3'h0;
          bit_next   = 4'h0;
          sr_next    = buf_reg[0];
          sck_next   = 1'b1;
          last_next  = 1'b0;
          consume    = 1'b1;
        end
      end
      ST_SHIFT: begin
        if (fall_ev) begin
          so_next = sr_reg[0];
          sr_next = {1'b0, sr_reg[7:1]};
          if (!ext) begin
            sck_next = 1'b0;
          end
          if (bit_reg == 4'h0) begin
            pend_next = nx_word;
          end
        end
        if (rise_ev) begin
          rx_next  = rx_sh;
          bit_next = bit_reg + 4'h1;
          if (!ext) begin
            sck_next = 1'b1;
          end
        end
        if (word_end) begin
          bit_next = 4'h0;
          idx_next = nidx;
          sr_next  = burst ? buf_reg[0] : pend_reg;
          if (is_rx && !last_reg) begin
            buf_next[idx_reg] = four ? {4'h0, rx_sh[7:4]} : rx_sh;
          end
          irq_next = burst && !last_reg;
          if (!run_reg || last_reg) begin
            state_next = ST_IDLE;
            run_next   = run_reg && !last_reg;
          end else if (burst && !acc_reg && !ext) begin
            state_next = ST_HOLD;
          end else if (burst && !acc_reg) begin
            last_next = 1'b1;
          end else begin
            consume  = burst;
            gap_next = 7'h00;
            if (!ext && gap_tgt != 7'h00) begin
              state_next = ST_GAP;
            end
          end
        end
      end
      ST_GAP: begin
        if (tick) begin
          gap_next = gap_reg + 7'h01;
          if (gap_reg == gap_tgt - 7'h01) begin
            state_next = ST_SHIFT;
          end
        end
      end
      ST_HOLD: begin
        if (!run_reg) begin
          state_next = ST_IDLE;
        end else if (acc_reg) begin
          state_next = ST_SHIFT;
          sr_next    = buf_reg[0];
          consume    = 1'b1;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
    if (abort_reg) begin
      state_next = ST_IDLE;
      run_next   = 1'b0;
      sck_next   = 1'b1;
      irq_next   = 1'b0;
    end
    acc_next = (acc_reg && !consume) ||
               (is_rx && mode_reg != MODE_TRX8 ? rd_buf : wr_buf);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      run_reg   <= 1'b0;
      abort_reg <= 1'b0;
      mode_reg  <= MODE_RST;
      sel_reg   <= SCK_RST;
      wait_reg  <= WAIT_RST;
      count_reg <= COUNT_RST;
      tap_reg   <= TAP_RST;
      buf_reg   <= '{default: 8'h00};
      state_reg <= ST_IDLE;
      idx_reg   <= 3'h0;
      bit_reg   <= 4'h0;
      sr_reg    <= 8'h00;
      rx_reg    <= 8'h00;
      pend_reg  <= 8'h00;
      div_reg   <= 13'h0000;
      gap_reg   <= 7'h00;
      sck_reg   <= 1'b1;
      oe_reg    <= 1'b1;
      so_reg    <= 1'b1;
      irq_reg   <= 1'b0;
      last_reg  <= 1'b0;
      acc_reg   <= 1'b0;
    end else begin
      run_reg   <= run_next;
      abort_reg <= abort_next;
      mode_reg  <= mode_next;
      sel_reg   <= sel_next;
      wait_reg  <= wait_next;
      count_reg <= count_next;
      tap_reg   <= tap_next;
      buf_reg   <= buf_next;
      state_reg <= state_next;
      idx_reg   <= idx_next;
      bit_reg   <= bit_next;
      sr_reg    <= sr_next;
      rx_reg    <= rx_next;
      pend_reg  <= pend_next;
      div_reg   <= div_next;
      gap_reg   <= gap_next;
      sck_reg   <= sck_next;
      oe_reg    <= oe_next;
      so_reg    <= so_next;
      irq_reg   <= irq_next;
      last_reg  <= last_next;
      acc_reg   <= acc_next;
    end
  end

  assign serial_clock_pin_o  = sck_reg;
  assign serial_clock_pin_oe = oe_reg;
  assign serial_out_pin      = so_reg;
  assign port_irq            = irq_reg;

  //////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_abort_stop;
    (wr_c1 && hwdata[ABORT_BIT]) |=> abort_reg ##1 !xfer_act;
  endproperty
  a_abort_stop: assert property (p_abort_stop)
    else $error("abort did not stop the transfer");

  property p_abort_self;
    (abort_reg && !wr_c1) |=> !abort_reg;
  endproperty
  a_abort_self: assert property (p_abort_self)
    else $error("abort bit did not clear itself");

  property p_count_hold;
    !wr_c2 |=> $stable(count_reg);
  endproperty
  a_count_hold: assert property (p_count_hold)
    else $error("word count changed without a write");

  property p_status;
    (ap && !hwrite && haddr[13:2] == IDX_STATUS) |=>
      hrdata_reg[7] == $past(xfer_act) && hrdata_reg[6] == $past(shift_act);
  endproperty
  a_status: assert property (p_status)
    else $error("status read does not match engine state");

  property p_nibble;
    (word_end && four && is_rx && !last_reg && !abort_reg) |=>
      buf_reg[$past(idx_reg)][7:4] == 4'h0;
  endproperty
  a_nibble: assert property (p_nibble)
    else $error("4-bit receive left upper nibble set");

  property p_sck_start;
    (state_reg == ST_IDLE && state_next == ST_SHIFT && !ext) |=>
      serial_clock_pin_o && serial_clock_pin_oe && idx_reg == 3'h0;
  endproperty
  a_sck_start: assert property (p_sck_start)
    else $error("clock pin not high and driven at start");

  property p_out_fall;
    $changed(so_reg) |-> $past(fall_ev);
  endproperty
  a_out_fall: assert property (p_out_fall)
    else $error("serial out changed away from a falling edge");

  property p_lsb;
    (fall_ev && bit_reg == 4'h0 && !abort_reg) |=> so_reg == $past(sr_lsb);
  endproperty
  a_lsb: assert property (p_lsb)
    else $error("first bit out is not the word lsb");

  property p_irq;
    (word_end && burst && !last_reg && !abort_reg) |=> port_irq;
  endproperty
  a_irq: assert property (p_irq)
    else $error("no interrupt after the last word");

  property p_idx_step;
    (word_end && !burst && !abort_reg) |=> idx_reg == $past(idx_reg) + 3'h1;
  endproperty
  a_idx_step: assert property (p_idx_step)
    else $error("buffer entry did not advance by one");

  property p_wait_enter;
    (word_end && burst && !acc_reg && run_reg && !last_reg && !ext &&
     !abort_reg) |=> state_reg == ST_HOLD ##1 serial_clock_pin_o;
  endproperty
  a_wait_enter: assert property (p_wait_enter)
    else $error("no automatic wait when data were missing");

  property p_hold;
    (state_reg == ST_HOLD && !acc_reg && run_reg && !abort_reg) |=>
      state_reg == ST_HOLD && $stable(sck_reg);
  endproperty
  a_hold: assert property (p_hold)
    else $error("clock moved during automatic wait");

  property p_run_stop;
    (word_end && !run_reg && !abort_reg) |=> !xfer_act;
  endproperty
  a_run_stop: assert property (p_run_stop)
    else $error("stop did not end at the word boundary");

  property p_pend;
    (fall_ev && bit_reg == 4'h0 && !abort_reg) |=>
      pend_reg == $past(nx_word);
  endproperty
  a_pend: assert property (p_pend)
    else $error("next word not loaded after first bit");

  property p_dummy;
    (word_end && burst && !acc_reg && ext && run_reg && !last_reg &&
     !abort_reg) |=> last_reg && shift_act;
  endproperty
  a_dummy: assert property (p_dummy)
    else $error("external clock did not arm the dummy word");

  c_start: cover property (state_reg == ST_IDLE && state_next == ST_SHIFT);
  c_hold:  cover property (state_reg == ST_HOLD);
  c_gap:   cover property (state_reg == ST_GAP);
  c_abort: cover property (abort_reg && shift_act);

endmodule : csp_port

// ===== hdl/csp_sync.sv
`timescale 1ns/1ps
module csp_sync (
  // Clock and reset
  input  wire logic hclk,
  input  wire logic hresetn,
  // Asynchronous input
  input  wire logic pin_i,
  // Settled level
  output logic      level_o
);

  logic s1_reg;
  logic s2_reg;
  logic s3_reg;
  logic level_reg;
  logic level_next;

  // Level follows once the second and third stages agree
  always_comb begin
    level_next = level_reg;
    if (s2_reg == s3_reg) begin
      level_next = s3_reg;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1_reg    <= 1'b1;
      s2_reg    <= 1'b1;
      s3_reg    <= 1'b1;
      level_reg <= 1'b1;
    end else begin
      s1_reg    <= pin_i;
      s2_reg    <= s1_reg;
      s3_reg    <= s2_reg;
      level_reg <= level_next;
    end
  end

  assign level_o = level_reg;

endmodule : csp_sync

// ===== verification/csp_peer.sv
`timescale 1ns/1ps
module csp_peer (
  // Link pins
  input  wire logic        sck,
  input  wire logic        so,
  output logic             si,
  // Bench control
  input  wire logic        clr,
  input  wire logic [63:0] pat,
  output logic [63:0]      cap
);
  logic [5:0] ni;
  logic [5:0] nc;
  initial si = 1'b1;
  always @(negedge sck or posedge clr) begin
    if (clr) begin
      ni = 6'h0;
    end else begin
      si = pat[ni]; // Next bit after fall
      ni = ni + 6'h1;
    end
  end
  always @(posedge sck or posedge clr) begin
    if (clr) begin
      nc = 6'h0;
      cap = '0;
    end else begin
      cap[nc] = so; // Take bit on rise
      nc = nc + 6'h1;
    end
  end
endmodule : csp_peer

// ===== verification/tb_csp_port.sv
`timescale 1ns/1ps
module tb_csp_port;
  import csp_pkg::*;
  logic        hclk, hresetn, hwrite, irq, sck_o, sck_oe, so, si, lowclk, clr;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [63:0] pat, cap;
  logic        xck = 1'b1;
  logic [7:0]  bufv [8];
  logic [2:0]  modes [5] = '{MODE_TX8, MODE_TX4, MODE_RX8, MODE_RX4, MODE_TRX8};
  wire         hrdy, hresp;
  wire         sck = sck_oe ? sck_o : xck;
  int          failures, checks_done;

  csp_port i_csp_port (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hrdy), .hrdata(hrdata), .hreadyout(hrdy),
    .hresp(hresp), .serial_clock_pin_i(sck), .serial_clock_pin_o(sck_o),
    .serial_clock_pin_oe(sck_oe), .serial_out_pin(so), .serial_in_pin(si),
    .lowclk_pin(lowclk), .port_irq(irq));
  csp_peer i_csp_peer (.sck(sck), .so(so), .si(si), .clr(clr), .pat(pat),
    .cap(cap));

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic bus(input logic wr, input logic [11:0] idx,
                     input logic [7:0] wd, output logic [31:0] rd);
    @(posedge hclk);
    htrans <= 2'b10;
    hwrite <= wr;
    haddr <= {18'h0, idx, 2'b00};
    @(posedge hclk);
    while (hrdy !== 1'b1) @(posedge hclk);
    htrans <= 2'b00;
    hwdata <= {24'h0, wd};
    @(posedge hclk);
    while (hrdy !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask : bus

  task automatic xpulses(input int n);
    repeat (n) begin
      #32 xck <= 1'b0; // Levels last over six clocks
      #32 xck <= 1'b1;
    end
  endtask : xpulses

  task automatic tally_and_finish;
    $display("Checks done %0d, failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : tally_and_finish

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end
  initial begin
    lowclk = 1'b0;
    forever #32 lowclk = ~lowclk;
  end
  initial begin
    #300000;
    failures++;
    tally_and_finish();
  end

  initial begin
    logic [31:0] rd;
    logic [2:0]  cnt, code, m;
    logic [7:0]  mask;
    int          n, bits, hp;
    {hresetn, htrans, hwrite, haddr, hwdata, clr, pat} = '0;
    void'($urandom(32'h7d0e7cfe));
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (3) @(posedge hclk);
    bus(1'b0, IDX_STATUS, 8'h0, rd);
    check(rd, 32'h0); // Idle status
    bus(1'b0, 12'h000, 8'h0, rd);
    check(rd, 32'h0); // Unmapped read
    check(32'(hresp), 32'h0); // Always OKAY
    for (int i = 0; i < 5; i++) begin
      m = modes[i];
      bits = (m == MODE_TX4 || m == MODE_RX4) ? 4 : 8;
      mask = (bits == 4) ? 8'h0f : 8'hff;
      cnt = (i == 4) ? 3'h7 : 3'($urandom_range(2));
      code = (i == 4) ? 3'($urandom_range(5, 4)) : 3'($urandom_range(5, 1));
      hp = int'(HALF_FC_CODE1 >> (code - 3'h1));
      pat <= {$urandom, $urandom};
      clr <= 1'b1;
      @(posedge hclk);
      clr <= 1'b0;
      for (int w = 0; w < 8; w++) begin
        bufv[w] = 8'($urandom);
        bus(1'b1, IDX_BUF_FIRST + 12'(w), bufv[w], rd);
      end
      bus(1'b1, IDX_CTRL_ONE, {2'b01, m, code}, rd); // Abort to set up
      bus(1'b1, IDX_CTRL_TWO, {3'h0, 2'(i == 4), cnt}, rd);
      bus(1'b1, IDX_CTRL_ONE, {2'b10, m, code}, rd);
      bus(1'b0, IDX_STATUS, 8'h0, rd);
      check(rd, 32'hc0); // Busy
      n = 0;
      while (irq !== 1'b1 && n < 20000) begin
        @(posedge hclk);
        n++;
      end
      check(32'(n < 20000), 32'h1); // Burst done
      if (i == 4)
        check(32'(n > 230 * hp && n < 240 * hp), 32'h1); // Frame wait
      repeat (4) @(posedge hclk);
      bus(1'b0, IDX_STATUS, 8'h0, rd);
      check(rd, 32'h80); // Held in wait
      for (int w = 0; w <= int'(cnt); w++) begin
        if (m != MODE_RX8 && m != MODE_RX4)
          check(32'((cap >> (w * bits)) & mask), 32'(bufv[w] & mask));
        if (m != MODE_TX8 && m != MODE_TX4) begin
          bus(1'b0, IDX_BUF_FIRST + 12'(w), 8'h0, rd);
          check(rd, 32'((pat >> (w * bits)) & mask));
        end
      end
      bus(1'b1, IDX_CTRL_ONE, {2'b01, m, code}, rd);
      repeat (3) @(posedge hclk);
      bus(1'b0, IDX_STATUS, 8'h0, rd);
      check(rd, 32'h0); // Abort stops
    end
    // External clock: one word, one refill, then a dummy word and stop
    clr <= 1'b1;
    @(posedge hclk);
    clr <= 1'b0;
    bufv[0] = 8'($urandom);
    bufv[1] = 8'($urandom);
    bus(1'b1, IDX_BUF_FIRST, bufv[0], rd);
    bus(1'b1, IDX_CTRL_ONE, {2'b01, MODE_TX8, CLK_EXT}, rd);
    bus(1'b1, IDX_CTRL_TWO, 8'h00, rd); // Stopped, one word
    bus(1'b1, IDX_CTRL_ONE, {2'b10, MODE_TX8, CLK_EXT}, rd);
    xpulses(4);
    bus(1'b1, IDX_BUF_FIRST, bufv[1], rd); // Refill in time
    xpulses(20);
    repeat (8) @(posedge hclk);
    bus(1'b0, IDX_STATUS, 8'h0, rd);
    check(rd, 32'h0); // Dummy word ends the run
    check(32'(cap[15:0]), {16'h0, bufv[1], bufv[0]});
    bus(1'b1, IDX_CTRL_ONE, {2'b01, MODE_TX8, CLK_RSVD}, rd);
    bus(1'b1, IDX_CTRL_ONE, {2'b10, MODE_TX8, CLK_RSVD}, rd);
    bus(1'b0, IDX_STATUS, 8'h0, rd);
    check(rd, 32'h0); // Reserved clock refused
    bus(1'b1, IDX_CTRL_ONE, {2'b01, 3'h1, 3'h5}, rd);
    bus(1'b1, IDX_CTRL_ONE, {2'b10, 3'h1, 3'h5}, rd);
    bus(1'b0, IDX_STATUS, 8'h0, rd);
    check(rd, 32'h0); // Reserved mode refused
    tally_and_finish();
  end
endmodule : tb_csp_port
